//--- common/irq_stack_pkg.sv
// shared constants and types for the stack and interrupt control block
package irq_stack_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // i/o register offsets
  localparam logic [5:0] SP_LO_OFS = 6'h10;
  localparam logic [5:0] SP_HI_OFS = 6'h11;
  localparam logic [5:0] FLAG_OFS = 6'h12;
  localparam logic [5:0] GIC_OFS = 6'h13;
  localparam logic [5:0] IEN_OFS = 6'h14;
  localparam logic [5:0] IPEND_OFS = 6'h15;

  // field positions
  localparam int GIE_BIT = 7;
  localparam int VTS_BIT = 1;

  // values after reset
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] GIC_RST = 8'h00;
  localparam logic [7:0] IEN_RST = 8'h00;

  // vector layout: words between two vectors, reset sits at index zero
  localparam logic [15:0] VEC_STRIDE = 16'h0002;
  localparam logic [15:0] VEC_LOW_BASE = 16'h0000;

  // byte counts moved by each stack operation
  localparam logic [1:0] ONE_BYTE = 2'h1;
  localparam logic [1:0] TWO_BYTES = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // stack operations requested by the core
  typedef enum logic [2:0] {
    OP_PUSH,
    OP_POP,
    OP_CALL,
    OP_SUB_RETURN,
    OP_IRQ_RETURN
  } stack_op_t;

  typedef struct packed {
    logic valid;
    stack_op_t kind;
    logic [15:0] data;
  } stack_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_port_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
  } io_req_t;

endpackage

//--- dv/stack_and_interrupt_control_bench.sv
// self-checking bench for the stack and interrupt control block
`timescale 1ns/1ps
module stack_and_interrupt_control_bench;
  localparam logic [15:0] BOOT = 16'h1800;
  logic ref_clk = 0, nrst = 0, instr_boundary = 1, sei_instr = 0, cli_instr = 0;
  logic boot_reset_fuse = 0, app_section_lock_bit = 0, boot_section_lock_bit = 0;
  logic op_ready, op_done_q, irq_vector_valid_q, global_irq_enable;
  logic [15:0] pc = 16'h0123, op_result_q, irq_vector_q, reset_vector_q, r;
  logic [7:0] mem_rdata, io_rdata_q, src_event = 0, src_level = 0;
  irq_stack_pkg::stack_req_t op_req = '0;
  irq_stack_pkg::io_req_t io = '0;
  irq_stack_pkg::mem_port_t mem;
  int err_total = 0, samples_checked = 0, vec_count = 0, n;

  stack_and_interrupt_control #(.LEVEL_MASK(8'h80), .BOOT_START(BOOT)) DUT (.ref_clk, .nrst,
    .op_req, .op_ready, .op_done_q, .op_result_q, .instr_boundary, .pc, .sei_instr,
    .cli_instr, .mem, .mem_rdata, .io, .io_rdata_q, .src_event, .src_level,
    .boot_reset_fuse, .app_section_lock_bit, .boot_section_lock_bit, .irq_vector_valid_q,
    .irq_vector_q, .reset_vector_q, .global_irq_enable);
  stack_mem_model ram (.ref_clk, .mem, .mem_rdata);

  ////////////////////////////////////////////////////////////////////////////
  // clock, entry counter, watchdog
  initial begin
    forever #50 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (irq_vector_valid_q === 1'b1) vec_count++;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    err_total++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // compare, register access and stack requests
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(posedge ref_clk) io <= {1'b1, 1'b0, a, d};
    @(posedge ref_clk) io <= '0;
  endtask
  task automatic rd(input logic [5:0] a, input logic [7:0] e);
    @(posedge ref_clk) io <= {1'b0, 1'b1, a, 8'h00};
    @(posedge ref_clk) io <= '0;
    #1 chk("io_rdata", {8'h00, e}, {8'h00, io_rdata_q});
  endtask
  task automatic rd_sp(input logic [15:0] e);
    rd(irq_stack_pkg::SP_LO_OFS, e[7:0]);
    rd(irq_stack_pkg::SP_HI_OFS, e[15:8]);
  endtask
  task automatic sop(input irq_stack_pkg::stack_op_t k, input logic [15:0] d);
    int i;
    @(posedge ref_clk) op_req <= {1'b1, k, d};
    @(negedge ref_clk);
    for (i = 0; i < 20 && op_ready !== 1'b1; i++) @(negedge ref_clk);
    @(posedge ref_clk) op_req <= '0;
    @(negedge ref_clk);
    for (i = 0; i < 20 && op_done_q !== 1'b1; i++) @(negedge ref_clk);
    chk("op_done", 16'h0001, {15'h0, op_done_q});
    r = op_result_q;
  endtask
  task automatic pulse_sei();
    @(posedge ref_clk) sei_instr <= 1'b1;
    @(posedge ref_clk) sei_instr <= 1'b0;
  endtask
  task automatic wait_vec(input logic [15:0] e);
    int i;
    for (i = 0; i < 50 && irq_vector_valid_q !== 1'b1; i++) @(negedge ref_clk);
    chk("irq_vector_valid", 16'h0001, {15'h0, irq_vector_valid_q});
    chk("irq_vector", e, irq_vector_q);
    @(negedge ref_clk);
  endtask
  task automatic do_reset();
    nrst <= 1'b0;
    repeat (10) @(posedge ref_clk);
    nrst <= 1'b1;
    repeat (2) @(posedge ref_clk);
  endtask
  task automatic complete_run();
    if (err_total == 0 && samples_checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // scenarios
  initial begin
    do_reset();
    rd_sp(16'h0000);
    chk("reset_vector", 16'h0000, reset_vector_q);
    wr(irq_stack_pkg::SP_LO_OFS, 8'hff);
    wr(irq_stack_pkg::SP_HI_OFS, 8'h00);
    wr(irq_stack_pkg::FLAG_OFS, 8'h2a);
    sop(irq_stack_pkg::OP_PUSH, 16'h00a5);
    rd_sp(16'h00fe);
    chk("stack_byte", 16'h00a5, {8'h00, ram.m[8'hff]});
    sop(irq_stack_pkg::OP_POP, 16'h0000);
    chk("pop_data", 16'h00a5, r);
    rd_sp(16'h00ff);
    sop(irq_stack_pkg::OP_CALL, 16'h1234);
    rd_sp(16'h00fd);
    chk("saved_addr", 16'h1234, {ram.m[8'hfe], ram.m[8'hff]});
    sop(irq_stack_pkg::OP_SUB_RETURN, 16'h0000);
    chk("return_data", 16'h1234, r);
    rd_sp(16'h00ff);
    // latched flags, priority and entry
    wr(irq_stack_pkg::IEN_OFS, 8'h06);
    @(posedge ref_clk) src_event <= 8'h0e;
    @(posedge ref_clk) src_event <= 8'h00;
    rd(irq_stack_pkg::IPEND_OFS, 8'h0e);
    pulse_sei();
    wait_vec(16'h0004);
    chk("gie", 16'h0000, {15'h0, global_irq_enable});
    rd(irq_stack_pkg::IPEND_OFS, 8'h0c);
    rd_sp(16'h00fd);
    rd(irq_stack_pkg::FLAG_OFS, 8'h2a);
    sop(irq_stack_pkg::OP_IRQ_RETURN, 16'h0000);
    chk("irq_return_data", pc, r);
    chk("gie", 16'h0001, {15'h0, global_irq_enable});
    wait_vec(16'h0006);
    rd(irq_stack_pkg::IPEND_OFS, 8'h08);
    wr(irq_stack_pkg::IPEND_OFS, 8'h00);
    rd(irq_stack_pkg::IPEND_OFS, 8'h08);
    wr(irq_stack_pkg::IPEND_OFS, 8'h08);
    rd(irq_stack_pkg::IPEND_OFS, 8'h00);
    sop(irq_stack_pkg::OP_IRQ_RETURN, 16'h0000);
    // disable in the same cycle as a pending request
    @(posedge ref_clk) instr_boundary <= 1'b0;
    src_event <= 8'h02;
    @(posedge ref_clk) src_event <= 8'h00;
    repeat (3) @(posedge ref_clk);
    n = vec_count;
    cli_instr <= 1'b1;
    instr_boundary <= 1'b1;
    @(posedge ref_clk) cli_instr <= 1'b0;
    repeat (10) @(posedge ref_clk);
    chk("entries", n, vec_count);
    rd(irq_stack_pkg::IPEND_OFS, 8'h02);
    // boot lock suppression, then vectors in boot section
    wr(irq_stack_pkg::GIC_OFS, 8'h02);
    @(posedge ref_clk) app_section_lock_bit <= 1'b1;
    pulse_sei();
    repeat (12) @(posedge ref_clk);
    chk("entries", n, vec_count);
    app_section_lock_bit <= 1'b0;
    wait_vec(BOOT + 16'h0004);
    sop(irq_stack_pkg::OP_IRQ_RETURN, 16'h0000);
    // level source gone before enabling, then present
    @(posedge ref_clk) cli_instr <= 1'b1;
    @(posedge ref_clk) cli_instr <= 1'b0;
    wr(irq_stack_pkg::IEN_OFS, 8'h80);
    src_level <= 8'h80;
    repeat (2) @(posedge ref_clk);
    src_level <= 8'h00;
    n = vec_count;
    pulse_sei();
    repeat (12) @(posedge ref_clk);
    chk("entries", n, vec_count);
    src_level <= 8'h80;
    wait_vec(BOOT + 16'h0010);
    @(posedge ref_clk) src_level <= 8'h00;
    sop(irq_stack_pkg::OP_IRQ_RETURN, 16'h0000);
    // second reset with the boot reset fuse programmed
    @(posedge ref_clk) boot_reset_fuse <= 1'b1;
    do_reset();
    chk("reset_vector", BOOT, reset_vector_q);
    chk("gie", 16'h0000, {15'h0, global_irq_enable});
    rd_sp(16'h0000);
    complete_run();
  end
endmodule // stack_and_interrupt_control_bench

//--- dv/stack_and_interrupt_control_properties.sv
// checker for stack walks, global enable and interrupt entry timing
`timescale 1ns/1ps
module irq_stack_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // stack requests
  input wire irq_stack_pkg::stack_req_t op_req,
  input wire logic op_ready,
  input wire logic op_done_q,
  input wire irq_stack_pkg::mem_port_t mem,
  // interrupt side
  input wire logic sei_instr,
  input wire logic cli_instr,
  input wire logic irq_vector_valid_q,
  input wire logic global_irq_enable
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////////////////////////////////////////
  // accepted request of each kind
  logic acc;
  assign acc = op_req.valid && op_ready;

  a_push_walk: assert property (acc && op_req.kind == irq_stack_pkg::OP_PUSH
    |=> mem.wr ##2 op_done_q) else $error("push walk wrong");
  a_call_walk: assert property (acc && op_req.kind == irq_stack_pkg::OP_CALL
    |=> mem.wr ##1 (mem.wr && mem.addr == $past(mem.addr) - 16'h1) ##2 op_done_q)
    else $error("call walk wrong");
  a_pop_walk: assert property (acc && op_req.kind == irq_stack_pkg::OP_POP
    |=> mem.rd && !mem.wr ##[2:3] op_done_q) else $error("pop walk wrong");
  a_sub_return_walk: assert property (acc && op_req.kind == irq_stack_pkg::OP_SUB_RETURN
    |=> mem.rd ##1 (mem.rd && mem.addr == $past(mem.addr) + 16'h1) ##[2:3] op_done_q)
    else $error("return walk wrong");
  a_return_gie: assert property (acc && op_req.kind == irq_stack_pkg::OP_IRQ_RETURN
    |-> ##[4:5] global_irq_enable) else $error("interrupt return left enable low");
  a_return_gap: assert property (acc && op_req.kind == irq_stack_pkg::OP_IRQ_RETURN
    |-> ##8 !irq_vector_valid_q) else $error("no instruction after interrupt return");
  a_stack_down: assert property (mem.wr && $past(mem.wr)
    |-> mem.addr == $past(mem.addr) - 16'h1) else $error("stack write not downward");
  a_take_needs_gie: assert property (irq_vector_valid_q
    |-> $past(global_irq_enable, 4)) else $error("entry without global enable");
  a_entry_walk: assert property (irq_vector_valid_q
    |-> !$past(global_irq_enable, 3) && $past(mem.wr, 3) && $past(mem.wr, 2))
    else $error("entry walk wrong");
  a_cli_blocks: assert property (cli_instr
    |-> ##4 !irq_vector_valid_q) else $error("entry taken with disable");
  a_sei_gap: assert property (sei_instr && !global_irq_enable
    |-> ##4 !irq_vector_valid_q ##1 !irq_vector_valid_q) else $error("no gap after enable");
endmodule // irq_stack_properties

bind stack_and_interrupt_control irq_stack_properties chk_i (.ref_clk, .nrst, .op_req,
  .op_ready, .op_done_q, .mem, .sei_instr, .cli_instr, .irq_vector_valid_q,
  .global_irq_enable);

//--- dv/stack_mem_model.sv
// data memory model holding the stack, answering the block's byte strobes
`timescale 1ns/1ps
module stack_mem_model (
  // clock
  input wire logic ref_clk,
  // memory port from the block
  input wire irq_stack_pkg::mem_port_t mem,
  output logic [7:0] mem_rdata
);
  logic [7:0] m [0:255];

  ////////////////////////////////////////////////////////////////////////////
  // byte store and read, data valid the cycle after the strobe only
  always @(posedge ref_clk) begin
    if (mem.wr) begin
      m[mem.addr[7:0]] <= mem.wdata;
    end
    if (mem.rd) begin
      mem_rdata <= m[mem.addr[7:0]];
    end else begin
      mem_rdata <= ~mem_rdata; // stale data never looks valid
    end
  end
endmodule // stack_mem_model

//--- verilog/irq_flag_bank.sv
// latched pending flags: set by events, cleared by entry or by write of one
`timescale 1ns/1ps
module irq_flag_bank #(
  parameter int N_SRC = 8
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // flag control
  input wire logic [N_SRC-1:0] set_i,
  input wire logic [N_SRC-1:0] hw_clr,
  input wire logic [N_SRC-1:0] sw_clr,
  // flag state
  output logic [N_SRC-1:0] flags_q
);

  initial begin
    if (N_SRC < 1 || N_SRC > 8) $error("irq_flag_bank: N_SRC must be 1..8");
  end

  ////////////////////////////////////////////////////////////////////////////
  // set wins over either clear in the same cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flags_q <= '0;
    end else begin
      flags_q <= (flags_q & ~(hw_clr | sw_clr)) | set_i;
    end
  end

endmodule // irq_flag_bank

//--- verilog/irq_priority_pick.sv
// picks the pending request with the lowest index, i.e. lowest vector
`timescale 1ns/1ps
module irq_priority_pick #(
  parameter int N_SRC = 8
) (
  // requests
  input wire logic [N_SRC-1:0] req,
  // winner
  output logic any,
  output logic [2:0] idx
);

  initial begin
    if (N_SRC < 1 || N_SRC > 8) $error("irq_priority_pick: N_SRC must be 1..8");
  end

  // scan from the top so the lowest set bit is the last one kept
  function automatic logic [2:0] lowest_set(input logic [N_SRC-1:0] v);
    logic [2:0] r;
    r = 3'h0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (v[i]) r = i[2:0];
    end
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  assign any = |req;
  assign idx = lowest_set(req);

endmodule // irq_priority_pick

//--- verilog/stack_and_interrupt_control.sv
// stack pointer, stack transfers and interrupt masking, priority and entry
`timescale 1ns/1ps
module stack_and_interrupt_control #(
  parameter int SP_W = 16,
  parameter int N_SRC = 8,
  parameter logic [7:0] LEVEL_MASK = 8'h00,
  parameter logic [15:0] BOOT_START = 16'h1800
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // core stack requests
  input wire irq_stack_pkg::stack_req_t op_req,
  output logic op_ready,
  output logic op_done_q,
  output logic [15:0] op_result_q,
  // core instruction flow
  input wire logic instr_boundary,
  input wire logic [15:0] pc,
  input wire logic sei_instr,
  input wire logic cli_instr,
  // data memory holding the stack
  output irq_stack_pkg::mem_port_t mem,
  input wire logic [7:0] mem_rdata,
  // i/o register port
  input wire irq_stack_pkg::io_req_t io,
  output logic [7:0] io_rdata_q,
  // interrupt sources
  input wire logic [N_SRC-1:0] src_event,
  input wire logic [N_SRC-1:0] src_level,
  // static configuration
  input wire logic boot_reset_fuse,
  input wire logic app_section_lock_bit,
  input wire logic boot_section_lock_bit,
  // vectoring to the core
  output logic irq_vector_valid_q,
  output logic [15:0] irq_vector_q,
  output logic [15:0] reset_vector_q,
  output logic global_irq_enable
);

  initial begin
    if (SP_W < 8 || SP_W > 16) $error("stack_and_interrupt_control: SP_W must be 8..16");
    if (N_SRC < 1 || N_SRC > 8) $error("stack_and_interrupt_control: N_SRC must be 1..8");
  end

  localparam logic [15:0] SP_MASK = 16'((32'h1 << SP_W) - 32'h1);
  localparam logic [N_SRC-1:0] LVL = LEVEL_MASK[N_SRC-1:0];

  typedef enum logic [1:0] {
    S_IDLE,
    S_WR,
    S_RD,
    S_WAIT
  } xfer_state_t;

  ////////////////////////////////////////////////////////////////////////////
  // state
  xfer_state_t st_q, st_d;
  irq_stack_pkg::stack_op_t kind_q;
  logic is_entry_q;
  logic [1:0] left_q;
  logic [15:0] data_q;
  logic rd_pend_q;
  logic [15:0] sp_q;
  logic gie_q;
  logic [6:0] flag_rest_q;
  logic [7:0] gic_q;
  logic [N_SRC-1:0] ien_q;
  logic hold_q;
  logic [N_SRC-1:0] pend_q;
  logic [15:0] vec_addr_q;

  // combinational
  logic accept;
  logic take;
  logic suppress;
  logic any_req;
  logic [2:0] win_idx;
  logic [N_SRC-1:0] req;
  logic [N_SRC-1:0] win_onehot;
  logic [N_SRC-1:0] sw_clr;
  logic [15:0] vec_base;
  logic xfer_done;
  logic irq_return_done;
  logic io_wr_at;

  function automatic logic [15:0] vec_of(input logic [15:0] base, input logic [2:0] i);
    return 16'(base + irq_stack_pkg::VEC_STRIDE * ({13'h0, i} + 16'h0001));
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // request masking and priority
  assign req = ((pend_q & ~LVL) | (src_level & LVL)) & ien_q;

  irq_priority_pick #(
    .N_SRC(N_SRC)
  ) u_pick (
    .req(req),
    .any(any_req),
    .idx(win_idx)
  );

  // boot lock: no interrupts while running in a locked section whose vectors live
  // in the other section
  assign suppress = (app_section_lock_bit && pc < BOOT_START && gic_q[irq_stack_pkg::VTS_BIT])
                 || (boot_section_lock_bit && pc >= BOOT_START
                     && !gic_q[irq_stack_pkg::VTS_BIT]);

  // taken only at an instruction end, with the engine free
  assign take = instr_boundary && st_q == S_IDLE && gie_q && !cli_instr
             && !hold_q && !suppress && any_req;
  assign op_ready = st_q == S_IDLE && !take;
  assign accept = op_req.valid && op_ready;

  assign win_onehot = N_SRC'(1) << win_idx;
  assign vec_base = gic_q[irq_stack_pkg::VTS_BIT] ? BOOT_START
                                                  : irq_stack_pkg::VEC_LOW_BASE;

  ////////////////////////////////////////////////////////////////////////////
  // latched flags
  assign io_wr_at = io.wr && io.addr == irq_stack_pkg::IPEND_OFS;
  assign sw_clr = io_wr_at ? io.wdata[N_SRC-1:0] : '0;

  irq_flag_bank #(
    .N_SRC(N_SRC)
  ) u_flags (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .set_i(src_event & ~LVL),
    .hw_clr(take ? (win_onehot & ~LVL) : '0),
    .sw_clr(sw_clr),
    .flags_q(pend_q)
  );

  ////////////////////////////////////////////////////////////////////////////
  // transfer engine next state
  always_comb begin
    st_d = st_q;
    case (st_q)
      S_IDLE: begin
        if (take) begin
          st_d = S_WR;
        end else if (accept) begin
          case (op_req.kind)
            irq_stack_pkg::OP_PUSH, irq_stack_pkg::OP_CALL: st_d = S_WR;
            default: st_d = S_RD;
          endcase
        end
      end
      S_WR: begin
        if (left_q == irq_stack_pkg::ONE_BYTE) st_d = S_WAIT;
      end
      S_RD: begin
        if (left_q == irq_stack_pkg::ONE_BYTE) st_d = S_WAIT;
      end
      S_WAIT: st_d = S_IDLE;
      default: st_d = S_IDLE;
    endcase
  end

  assign xfer_done = st_q == S_WAIT;
  assign irq_return_done = xfer_done && kind_q == irq_stack_pkg::OP_IRQ_RETURN && !is_entry_q;

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      st_q <= S_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // operation details captured on acceptance or on interrupt entry
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      kind_q <= irq_stack_pkg::OP_PUSH;
      is_entry_q <= 1'b0;
      left_q <= 2'h0;
      data_q <= 16'h0000;
    end else if (take) begin
      kind_q <= irq_stack_pkg::OP_CALL;
      is_entry_q <= 1'b1;
      left_q <= irq_stack_pkg::TWO_BYTES;
      data_q <= pc;
    end else if (accept) begin
      kind_q <= op_req.kind;
      is_entry_q <= 1'b0;
      case (op_req.kind)
        irq_stack_pkg::OP_PUSH, irq_stack_pkg::OP_POP: left_q <= irq_stack_pkg::ONE_BYTE;
        default: left_q <= irq_stack_pkg::TWO_BYTES;
      endcase
      data_q <= op_req.kind == irq_stack_pkg::OP_PUSH ? {8'h00, op_req.data[7:0]}
                                                       : op_req.data;
    end else if (st_q == S_WR || st_q == S_RD) begin
      left_q <= 2'(left_q - 2'h1);
      data_q <= {8'h00, data_q[15:8]}; // low byte first, high byte below it
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack memory port: writes at the pointer, reads one above it
  always_comb begin
    mem.wr = st_q == S_WR;
    mem.rd = st_q == S_RD;
    mem.addr = st_q == S_RD ? 16'((sp_q + 16'h0001) & SP_MASK) : sp_q;
    mem.wdata = data_q[7:0];
  end

  // read data returns one cycle after the strobe; high byte comes first
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= st_q == S_RD;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      op_result_q <= 16'h0000;
    end else if (accept) begin
      op_result_q <= 16'h0000;
    end else if (rd_pend_q) begin
      op_result_q <= {op_result_q[7:0], mem_rdata};
    end
  end

  // completion pulse for core requests, vector pulse for entries
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      op_done_q <= 1'b0;
      irq_vector_valid_q <= 1'b0;
    end else begin
      op_done_q <= xfer_done && !is_entry_q;
      irq_vector_valid_q <= xfer_done && is_entry_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // stack pointer: engine moves it, software loads it when the engine is idle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      sp_q <= irq_stack_pkg::SP_RST;
    end else if (st_q == S_WR) begin
      sp_q <= 16'((sp_q - 16'h0001) & SP_MASK);
    end else if (st_q == S_RD) begin
      sp_q <= 16'((sp_q + 16'h0001) & SP_MASK);
    end else if (io.wr && io.addr == irq_stack_pkg::SP_LO_OFS) begin
      sp_q <= {sp_q[15:8], io.wdata} & SP_MASK;
    end else if (io.wr && io.addr == irq_stack_pkg::SP_HI_OFS) begin
      sp_q <= {io.wdata, sp_q[7:0]} & SP_MASK;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // global enable: entry clears, return sets, then disable, enable, write
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      gie_q <= irq_stack_pkg::FLAG_RST[irq_stack_pkg::GIE_BIT];
    end else if (take) begin
      gie_q <= 1'b0;
    end else if (irq_return_done) begin
      gie_q <= 1'b1;
    end else if (cli_instr) begin
      gie_q <= 1'b0;
    end else if (sei_instr) begin
      gie_q <= 1'b1;
    end else if (io.wr && io.addr == irq_stack_pkg::FLAG_OFS) begin
      gie_q <= io.wdata[irq_stack_pkg::GIE_BIT];
    end
  end

  assign global_irq_enable = gie_q;

  // one-instruction hold after enable and after interrupt return
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      hold_q <= 1'b0;
    end else if (sei_instr || irq_return_done) begin
      hold_q <= 1'b1;
    end else if (instr_boundary) begin
      hold_q <= 1'b0;
    end
  end

  // remaining flag bits are plain storage, never saved or restored here
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      flag_rest_q <= irq_stack_pkg::FLAG_RST[6:0];
    end else if (io.wr && io.addr == irq_stack_pkg::FLAG_OFS) begin
      flag_rest_q <= io.wdata[6:0];
    end
  end

  // control and enable registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      gic_q <= irq_stack_pkg::GIC_RST;
      ien_q <= irq_stack_pkg::IEN_RST[N_SRC-1:0];
    end else begin
      if (io.wr && io.addr == irq_stack_pkg::GIC_OFS) gic_q <= io.wdata;
      if (io.wr && io.addr == irq_stack_pkg::IEN_OFS) ien_q <= io.wdata[N_SRC-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // vector address of the winner, held until the entry completes
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      vec_addr_q <= 16'h0000;
    end else if (take) begin
      vec_addr_q <= vec_of(vec_base, win_idx);
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      irq_vector_q <= 16'h0000;
    end else if (xfer_done && is_entry_q) begin
      irq_vector_q <= vec_addr_q;
    end
  end

  // reset vector follows the boot fuse, sampled every cycle
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      reset_vector_q <= irq_stack_pkg::VEC_LOW_BASE;
    end else begin
      reset_vector_q <= boot_reset_fuse ? BOOT_START : irq_stack_pkg::VEC_LOW_BASE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // i/o read port, one cycle latency; unmapped offsets read zero
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      io_rdata_q <= 8'h00;
    end else if (io.rd) begin
      case (io.addr)
        irq_stack_pkg::SP_LO_OFS: io_rdata_q <= sp_q[7:0];
        irq_stack_pkg::SP_HI_OFS: io_rdata_q <= sp_q[15:8];
        irq_stack_pkg::FLAG_OFS: io_rdata_q <= {gie_q, flag_rest_q};
        irq_stack_pkg::GIC_OFS: io_rdata_q <= gic_q;
        irq_stack_pkg::IEN_OFS: io_rdata_q <= 8'(ien_q);
        irq_stack_pkg::IPEND_OFS: io_rdata_q <= 8'(pend_q);
        default: io_rdata_q <= 8'h00;
      endcase
    end
  end

endmodule // stack_and_interrupt_control
